/* design/spi_exec_consts.svh */
// Constants for the serial instruction executor: opcodes, fields, offsets and reset values.
`ifndef SPI_EXEC_CONSTS_SVH
`define SPI_EXEC_CONSTS_SVH
`define OP_SUPPRESS_ACK   8'h40
`define OP_MASK_SET       8'h41
`define OP_MASK_CLR       8'h42
`define OP_MASK_OR        8'h43
`define OP_MASK_AND       8'h44
`define OP_BIT_SET        8'h45
`define OP_BIT_CLR        8'h46
`define OP_MEM_RD         4'h1
`define OP_MEM_WR         4'h2
`define RX_MASK_ONE       16'h2000
`define MASK_RESET        16'h0000
`define EXC_MISUSE        0
`define EXC_EMPTY         1
`define EXC_BADLOC        2
`define MEM_SIZE          12'h100
`define BIT_REG_LIMIT     12'h020
`define BIT_LAST          3'h7
`define REG_STATUS        12'h000
`define REG_CLEAR         12'h004
`define REG_IRQ_EN        12'h008
`define REG_CONTROL       12'h00c
`define REG_RX_MASK       12'h010
`define CTRL_AUTO_ACK     0
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

/* design/spi_exec_pkg.sv */
// Types shared by the serial instruction executor.
`include "spi_exec_consts.svh"
package spi_exec_pkg;
    typedef enum logic [2:0] {
        ST_OP   = 3'h0,
        ST_ARG1 = 3'h1,
        ST_ARG2 = 3'h3,
        ST_DATA = 3'h2,
        ST_SKIP = 3'h6
    } phase_type;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_STATUS, SEL_CLEAR, SEL_IRQ_EN, SEL_CONTROL, SEL_RX_MASK
    } reg_sel_type;

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_prev;
        logic        cs_s1;
        logic        cs_s2;
        logic        mosi_s1;
        logic        mosi_s2;
        phase_type   phase;
        logic [2:0]  bit_cnt;
        logic [7:0]  rx_shift;
        logic [7:0]  tx_shift;
        logic [7:0]  tx_pending;
        logic [7:0]  opcode;
        logic [7:0]  operand_hi;
        logic [11:0] addr;
        logic [7:0]  hold;
        logic        hold_valid;
        logic [15:0] mask;
        logic        ack_inhibit;
        logic        auto_ack;
        logic [2:0]  exc;
        logic [2:0]  irq_en;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_type;
endpackage

/* design/spi_instruction_executor.sv */
// Serial instruction executor with mask, bit and burst memory instructions.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spi_exec_consts.svh"
// What this block does
// - Suppress strobe blocks acknowledgement of current frame.
// - Suppression lasts only for the current frame.
// - Strobe outside a frame raises misuse, no acknowledgement.
// - Mask set strobe forces mask bit 13 high.
// - Mask clear strobe forces mask bit 13 low.
// - Mask OR instruction ORs 16-bit operand in.
// - Mask AND instruction ANDs 16-bit operand in.
// - Mask cleared to zero raises empty exception.
// - Bit set writes one to selected bit.
// - Bit clear writes zero to selected bit.
// - Bit operations leave other bits untouched.
// - Bit operations reach only addresses 0 to 31.
// - Burst read returns bytes from successive addresses.
// - Even read latches odd byte for next read.
// - Both word bytes come from one instant.
// - Burst write stores byte n at start plus n.
// - Burst write returns original contents before overwrite.
module spi_instruction_executor
    import spi_exec_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    input  wire logic        rx_frame_active,
    output logic             ack_enable,
    output logic [15:0]      rx_mask,
    output logic             irq,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    // ************************************************************
    // State and memory
    // ************************************************************
    state_type   s_reg;
    state_type   s_next;
    logic [7:0]  mem [0:255];
    logic        mem_we;
    logic [7:0]  mem_wa;
    logic [7:0]  mem_wd;
    logic [7:0]  rd_idx;
    logic [7:0]  mem_rd;
    logic [7:0]  mem_rd_odd;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [7:0]  byte_in;
    logic [7:0]  status_byte;
    logic [15:0] operand;
    logic [11:0] next_addr;
    logic [11:0] start_addr;
    logic [7:0]  bit_sel;
    logic        is_mem_op;
    logic        is_rd;
    logic        ev_suppress_ack_strobe;
    logic        ev_set;
    logic        ev_clr;
    logic        ev_or;
    logic        ev_and;
    logic        ev_bit;
    logic        ev_prep;
    logic        ev_badloc;
    logic        ev_memory_burst_write_instr;
    logic [2:0]  events;
    logic [2:0]  clr_bits;
    logic        aw_fire;
    logic        w_fire;
    logic        have_aw;
    logic        have_w;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    reg_sel_type wr_sel;
    reg_sel_type rd_sel;

    function automatic reg_sel_type reg_decode(input logic [11:0] a);
        if (a == `REG_STATUS) begin
            return SEL_STATUS;
        end else if (a == `REG_CLEAR) begin
            return SEL_CLEAR;
        end else if (a == `REG_IRQ_EN) begin
            return SEL_IRQ_EN;
        end else if (a == `REG_CONTROL) begin
            return SEL_CONTROL;
        end else if (a == `REG_RX_MASK) begin
            return SEL_RX_MASK;
        end else begin
            return SEL_NONE;
        end
    endfunction

    assign sclk_rise   = s_reg.sclk_s2 & ~s_reg.sclk_prev;
    assign sclk_fall   = ~s_reg.sclk_s2 & s_reg.sclk_prev;
    assign byte_in     = {s_reg.rx_shift[6:0], s_reg.mosi_s2};
    assign operand     = {s_reg.operand_hi, byte_in};
    assign next_addr   = 12'(s_reg.addr + 12'h001);
    assign start_addr  = {s_reg.addr[11:8], byte_in};
    assign bit_sel     = 8'h01 << byte_in[2:0];
    assign is_mem_op   = (s_reg.opcode[7:4] == `OP_MEM_RD) || (s_reg.opcode[7:4] == `OP_MEM_WR);
    assign is_rd       = s_reg.opcode[7:4] == `OP_MEM_RD;
    assign mem_rd      = mem[rd_idx];
    assign mem_rd_odd  = mem[rd_idx | 8'h01];
    assign status_byte = {1'h0, s_reg.ack_inhibit, s_reg.auto_ack, rx_frame_active,
                          (s_reg.mask == 16'h0000), s_reg.exc};
    assign awready     = ~s_reg.aw_held & ~s_reg.bvalid;
    assign wready      = ~s_reg.w_held & ~s_reg.bvalid;
    assign arready     = ~s_reg.rvalid;
    assign aw_fire     = awvalid & awready;
    assign w_fire      = wvalid & wready;
    assign have_aw     = s_reg.aw_held | aw_fire;
    assign have_w      = s_reg.w_held | w_fire;
    assign wr_addr     = aw_fire ? awaddr : s_reg.aw_addr;
    assign wr_data     = w_fire ? wdata : s_reg.w_data;
    assign wr_sel      = reg_decode(wr_addr);
    assign rd_sel      = reg_decode(araddr);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_next    = s_reg;
        mem_we    = 1'h0;
        mem_wa    = 8'h00;
        mem_wd    = 8'h00;
        rd_idx    = s_reg.addr[7:0];
        events    = 3'h0;
        clr_bits  = 3'h0;
        ev_suppress_ack_strobe  = 1'h0;
        ev_set    = 1'h0;
        ev_clr    = 1'h0;
        ev_or     = 1'h0;
        ev_and    = 1'h0;
        ev_bit    = 1'h0;
        ev_prep   = 1'h0;
        ev_badloc = 1'h0;
        ev_memory_burst_write_instr  = 1'h0;
        // Pins cross into this clock through two flops before anything reads them.
        s_next.sclk_s1   = sclk;
        s_next.sclk_s2   = s_reg.sclk_s1;
        s_next.sclk_prev = s_reg.sclk_s2;
        s_next.cs_s1     = cs_n;
        s_next.cs_s2     = s_reg.cs_s1;
        s_next.mosi_s1   = mosi;
        s_next.mosi_s2   = s_reg.mosi_s1;
        // Suppression dies with the frame it was issued for.
        s_next.ack_inhibit = s_reg.ack_inhibit & rx_frame_active;
        if (s_reg.cs_s2) begin
            s_next.phase      = ST_OP;
            s_next.bit_cnt    = 3'h0;
            s_next.tx_shift   = status_byte;
            s_next.hold_valid = 1'h0;
        end else if (sclk_rise) begin
            s_next.rx_shift = byte_in;
            s_next.bit_cnt  = 3'(s_reg.bit_cnt + 3'h1);
            if (s_reg.bit_cnt == `BIT_LAST) begin
                s_next.tx_pending = status_byte;
                case (s_reg.phase)
                    ST_OP: begin
                        s_next.opcode     = byte_in;
                        s_next.hold_valid = 1'h0;
                        s_next.phase      = ST_ARG1;
                        if (byte_in[7:4] == `OP_MEM_RD || byte_in[7:4] == `OP_MEM_WR) begin
                            s_next.addr[11:8] = byte_in[3:0];
                        end else if (byte_in == `OP_SUPPRESS_ACK) begin
                            ev_suppress_ack_strobe     = 1'h1;
                            s_next.phase = ST_OP;
                            if (rx_frame_active) begin
                                s_next.ack_inhibit = 1'h1;
                            end else begin
                                events[`EXC_MISUSE] = 1'h1;
                            end
                        end else if (byte_in == `OP_MASK_SET) begin
                            ev_set       = 1'h1;
                            s_next.phase = ST_OP;
                            s_next.mask  = s_reg.mask | `RX_MASK_ONE;
                        end else if (byte_in == `OP_MASK_CLR) begin
                            ev_clr       = 1'h1;
                            s_next.phase = ST_OP;
                            s_next.mask  = s_reg.mask & ~`RX_MASK_ONE;
                            events[`EXC_EMPTY] = s_next.mask == 16'h0000;
                        end else if (byte_in != `OP_MASK_OR && byte_in != `OP_MASK_AND &&
                                     byte_in != `OP_BIT_SET && byte_in != `OP_BIT_CLR) begin
                            // Unknown opcodes are skipped until the host deselects.
                            s_next.phase = ST_SKIP;
                        end
                    end
                    ST_ARG1: begin
                        if (s_reg.opcode == `OP_BIT_SET || s_reg.opcode == `OP_BIT_CLR) begin
                            // A five-bit field cannot leave the low register range.
                            ev_bit       = 1'h1;
                            rd_idx       = {3'h0, byte_in[7:3]};
                            mem_we       = 1'h1;
                            mem_wa       = rd_idx;
                            if (s_reg.opcode == `OP_BIT_SET) begin
                                mem_wd = mem_rd | bit_sel;
                            end else begin
                                mem_wd = mem_rd & ~bit_sel;
                            end
                            s_next.phase = ST_OP;
                        end else if (is_mem_op) begin
                            s_next.addr[7:0] = byte_in;
                            if (start_addr >= `MEM_SIZE) begin
                                ev_badloc = 1'h1;
                                events[`EXC_BADLOC] = 1'h1;
                                s_next.phase = ST_SKIP;
                            end else begin
                                ev_prep      = 1'h1;
                                rd_idx       = start_addr[7:0];
                                s_next.phase = ST_DATA;
                            end
                        end else begin
                            s_next.operand_hi = byte_in;
                            s_next.phase      = ST_ARG2;
                        end
                    end
                    ST_ARG2: begin
                        s_next.phase = ST_OP;
                        if (s_reg.opcode == `OP_MASK_OR) begin
                            ev_or       = 1'h1;
                            s_next.mask = s_reg.mask | operand;
                        end else begin
                            ev_and      = 1'h1;
                            s_next.mask = s_reg.mask & operand;
                            events[`EXC_EMPTY] = s_next.mask == 16'h0000;
                        end
                    end
                    ST_DATA: begin
                        if (!is_rd) begin
                            ev_memory_burst_write_instr = 1'h1;
                            mem_we   = 1'h1;
                            mem_wa   = s_reg.addr[7:0];
                            mem_wd   = byte_in;
                        end
                        if (next_addr >= `MEM_SIZE || next_addr == 12'h000) begin
                            ev_badloc = 1'h1;
                            events[`EXC_BADLOC] = 1'h1;
                            s_next.phase = ST_SKIP;
                        end else begin
                            ev_prep     = 1'h1;
                            rd_idx      = next_addr[7:0];
                            s_next.addr = next_addr;
                        end
                    end
                    default: begin
                        s_next.phase = ST_SKIP;
                    end
                endcase
                if (ev_prep) begin
                    // The byte is fetched before the write of this slot lands.
                    s_next.tx_pending = mem_rd;
                    if (is_rd && rd_idx[0] && s_reg.hold_valid) begin
                        s_next.tx_pending = s_reg.hold;
                        s_next.hold_valid = 1'h0;
                    end else if (is_rd && !rd_idx[0]) begin
                        s_next.hold       = mem_rd_odd;
                        s_next.hold_valid = 1'h1;
                    end else begin
                        s_next.hold_valid = 1'h0;
                    end
                end
            end
        end else if (sclk_fall) begin
            if (s_reg.bit_cnt == 3'h0) begin
                s_next.tx_shift = s_reg.tx_pending;
            end else begin
                s_next.tx_shift = {s_reg.tx_shift[6:0], 1'h0};
            end
        end
        // Register bus: address and data may arrive in either order.
        if (aw_fire) begin
            s_next.aw_held = 1'h1;
            s_next.aw_addr = awaddr;
        end
        if (w_fire) begin
            s_next.w_held = 1'h1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'h0;
        end
        if (have_aw && have_w && !s_reg.bvalid) begin
            s_next.aw_held = 1'h0;
            s_next.w_held  = 1'h0;
            s_next.bvalid  = 1'h1;
            s_next.bresp   = `RESP_OKAY;
            // Every writable field sits in the low byte lane, so only that strobe matters.
            if ((w_fire ? wstrb[0] : s_reg.w_strb[0]) && wr_sel == SEL_CLEAR) begin
                clr_bits = wr_data[2:0];
            end else if ((w_fire ? wstrb[0] : s_reg.w_strb[0]) && wr_sel == SEL_IRQ_EN) begin
                s_next.irq_en = wr_data[2:0];
            end else if ((w_fire ? wstrb[0] : s_reg.w_strb[0]) && wr_sel == SEL_CONTROL) begin
                s_next.auto_ack = wr_data[`CTRL_AUTO_ACK];
            end else if (wr_sel == SEL_NONE || wr_addr[1:0] != 2'h0) begin
                s_next.bresp = `RESP_SLVERR;
            end
        end
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'h0;
        end
        if (arvalid && arready) begin
            s_next.rvalid = 1'h1;
            s_next.rresp  = `RESP_OKAY;
            s_next.rdata  = 32'h0000_0000;
            if (rd_sel == SEL_STATUS) begin
                s_next.rdata[2:0] = s_reg.exc;
            end else if (rd_sel == SEL_IRQ_EN) begin
                s_next.rdata[2:0] = s_reg.irq_en;
            end else if (rd_sel == SEL_CONTROL) begin
                s_next.rdata[`CTRL_AUTO_ACK] = s_reg.auto_ack;
            end else if (rd_sel == SEL_RX_MASK) begin
                s_next.rdata[15:0] = s_reg.mask;
            end else if (rd_sel == SEL_NONE) begin
                s_next.rresp = `RESP_SLVERR;
            end
        end
        // A new event beats a clear written in the same cycle.
        s_next.exc = (s_reg.exc & ~clr_bits) | events;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.cs_s1 <= 1'h1;
            s_reg.cs_s2 <= 1'h1;
            s_reg.mask  <= `MASK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we && !rst) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign miso       = s_reg.tx_shift[7];
    assign miso_oe    = ~s_reg.cs_s2;
    assign ack_enable = s_reg.auto_ack & ~s_reg.ack_inhibit;
    assign rx_mask    = s_reg.mask;
    assign irq        = |(s_reg.exc & s_reg.irq_en);
    assign bvalid     = s_reg.bvalid;
    assign bresp      = s_reg.bresp;
    assign rvalid     = s_reg.rvalid;
    assign rdata      = s_reg.rdata;
    assign rresp      = s_reg.rresp;

    // ************************************************************
    // Checks
    // ************************************************************
    a_ack_blocked: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ev_suppress_ack_strobe && rx_frame_active) |=> (s_reg.ack_inhibit && !ack_enable))
        else $error("acknowledge not suppressed after strobe");

    a_inhibit_frame_end: assert property (
        @(posedge ref_clk) disable iff (rst)
        !rx_frame_active |=> !s_reg.ack_inhibit)
        else $error("suppression outlived its frame");

    a_misuse_raise: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ev_suppress_ack_strobe && !rx_frame_active) |=> (s_reg.exc[`EXC_MISUSE] && !s_reg.ack_inhibit))
        else $error("misuse not raised for strobe outside frame");

    a_mask_force_high: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_set |=> s_reg.mask == ($past(s_reg.mask) | `RX_MASK_ONE))
        else $error("mask set strobe wrong result");

    a_mask_force_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_clr |=> s_reg.mask == ($past(s_reg.mask) & ~`RX_MASK_ONE))
        else $error("mask clear strobe wrong result");

    a_mask_or_result: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_or |=> s_reg.mask == ($past(s_reg.mask) | $past(operand)))
        else $error("mask OR wrong result");

    a_mask_and_result: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_and |=> s_reg.mask == ($past(s_reg.mask) & $past(operand)))
        else $error("mask AND wrong result");

    a_empty_raise: assert property (
        @(posedge ref_clk) disable iff (rst)
        ((ev_and || ev_clr) && s_next.mask == 16'h0000) |=> s_reg.exc[`EXC_EMPTY])
        else $error("empty mask exception missing");

    a_bit_only_one: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_bit |-> (mem_we && ((mem_wd ^ mem_rd) & ~bit_sel) == 8'h00 &&
                    (((mem_wd & bit_sel) != 8'h00) == (s_reg.opcode == `OP_BIT_SET))))
        else $error("bit operation touched other bits or wrong value");

    a_bit_range: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_bit |-> {4'h0, mem_wa} < `BIT_REG_LIMIT)
        else $error("bit operation outside low register range");

    a_burst_next: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ev_prep && s_reg.phase == ST_DATA) |-> {4'h0, rd_idx} == next_addr)
        else $error("burst did not advance by one");

    a_word_atomic: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ev_prep && is_rd && rd_idx[0] && s_reg.hold_valid)
            |=> s_reg.tx_pending == $past(s_reg.hold))
        else $error("odd byte not taken from latched copy");

    a_write_addr: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_memory_burst_write_instr |-> (mem_we && mem_wa == s_reg.addr[7:0] && mem_wd == byte_in))
        else $error("burst write to wrong location");

    a_status_first: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reg.cs_s2 |=> s_reg.tx_shift == $past(status_byte))
        else $error("status byte not loaded before instruction");

    a_badloc_raise: assert property (
        @(posedge ref_clk) disable iff (rst)
        ev_badloc |=> (s_reg.exc[`EXC_BADLOC] && s_reg.phase == ST_SKIP))
        else $error("bad location not raised or access continued");

endmodule

/* tb/spi_host_model.sv */
// Host-side serial master model for the executor's link.
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic ref_clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Mode 0, one byte MSB first; the clock stands low outside frames.
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi <= d[i];
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            q[i] = miso;
            @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b0;
        end
    endtask
    // A released data line shows no stale value.
    task automatic fin();
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule

/* tb/spi_instruction_executor_tb.sv */
// Self-checking bench for the serial instruction executor.
`timescale 1ns/1ps
`include "spi_exec_consts.svh"
module spi_instruction_executor_tb;
    import spi_exec_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, rx_frame_active = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, r, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic sclk, cs_n, mosi, miso, miso_oe, ack_enable, irq, awready, wready, bvalid;
    logic arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [15:0] rx_mask;
    int          err_count = 0, n_compared = 0;
    always #20 ref_clk = ~ref_clk;
    spi_instruction_executor i_spi_instruction_executor (.ref_clk, .rst, .sclk, .cs_n,
        .mosi, .miso, .miso_oe, .rx_frame_active, .ack_enable, .rx_mask, .irq, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    spi_host_model i_spi_host_model (.ref_clk, .sclk, .cs_n, .mosi, .miso);
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge ref_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk);
            {ta, tw, tb} = {awvalid & awready, wvalid & wready, bvalid};
            if (tb) chk(bresp, `RESP_OKAY);
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                @(negedge ref_clk);
                return;
            end
        end
        chk(0, 1);
        end_of_test();
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge ref_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk);
            if (arready) begin
                @(posedge ref_clk);
                arvalid <= 1'b0;
            end else if (rvalid) begin
                r = rdata;
                chk(rresp, `RESP_OKAY);
                @(posedge ref_clk);
                rready <= 1'b0;
                return;
            end
        end
        chk(0, 1);
        end_of_test();
    endtask
    task automatic cmd(input logic [31:0] v, input int n);
        logic [7:0] q;
        for (int i = n - 1; i >= 0; i--) begin
            i_spi_host_model.xb(v[i*8+:8], q);
            r = {r[23:0], q};
        end
        i_spi_host_model.fin();
    endtask
    task automatic t_mask();
        cmd(`OP_MASK_SET, 1);
        chk(rx_mask, 16'h2000);
        cmd({`OP_MASK_OR, 16'h0081}, 3);
        chk(rx_mask, 16'h2081);
        cmd(`OP_MASK_CLR, 1);
        chk(rx_mask, 16'h0081);
        axw(`REG_IRQ_EN, 32'h2);
        cmd({`OP_MASK_AND, 16'h0100}, 3);
        chk(rx_mask, 16'h0000);
        chk(irq, 1'b1);
        axw(`REG_CLEAR, 32'h2);
        chk(irq, 1'b0);
        $display("mask test done");
    endtask
    task automatic t_ack();
        axw(`REG_CONTROL, 32'h1);
        @(posedge ref_clk);
        rx_frame_active <= 1'b1;
        cmd(`OP_SUPPRESS_ACK, 1);
        chk(ack_enable, 1'b0);
        @(posedge ref_clk);
        rx_frame_active <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rx_frame_active <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(ack_enable, 1'b1);
        @(posedge ref_clk);
        rx_frame_active <= 1'b0;
        cmd(`OP_SUPPRESS_ACK, 1);
        axr(`REG_STATUS);
        chk(r[0], 1'b1);
        $display("ack test done");
    endtask
    task automatic t_mem();
        cmd({`OP_MEM_WR, 12'h000, 16'h1122}, 4);
        cmd({`OP_BIT_SET, 8'h07}, 2);
        cmd({`OP_BIT_CLR, 8'h0d}, 2);
        cmd({`OP_MEM_RD, 12'h000, 16'h0000}, 4);
        chk(r[15:0], 16'h9102);
        chk(r[31:16], 16'h2929);
        cmd({`OP_MEM_WR, 12'h001, 8'h33}, 3);
        chk(r[7:0], 8'h02);
        cmd({`OP_MEM_RD, 12'h100, 8'h00}, 3);
        axr(`REG_STATUS);
        chk(r[2], 1'b1);
        $display("memory test done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_mask();
        t_ack();
        t_mem();
        end_of_test();
    end
endmodule
